// *** src/qdc_pkg.sv ***
package qdc_pkg;

    // frame geometry
    localparam int FRAME_BITS = 16;  // bits in one serial frame
    localparam int CODE_W = 12;  // converter code width
    localparam int NUM_CH = 4;  // output channels
    localparam logic [3:0] LAST_BIT = 4'hF;  // count value of the last bit
    localparam logic [11:0] CODE_FULL = 12'hFFF;  // full-scale code

    // timing
    localparam int CLK_MHZ = 40;  // pclk rate
    localparam int WAKEUP_DELAY_NS = 6000;  // wake-up time, ns
    // least time: round up to whole pclk cycles
    localparam int WAKEUP_CYCLES = (WAKEUP_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_W = 16;  // wake counter width

    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;  // control
    localparam logic [7:0] ADDR_STATUS = 8'h04;  // status
    localparam logic [7:0] ADDR_CH_BASE = 8'h10;  // channel 0 code

    // control fields and reset value
    localparam int CTRL_EN_BIT = 0;  // link enable
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;  // enabled

    // status fields
    localparam int ST_PD_BIT = 0;  // powered down
    localparam int ST_TERM_LSB = 1;  // termination, 2 bits
    localparam int ST_BUSY_BIT = 3;  // frame in progress
    localparam int ST_WAKE_BIT = 4;  // wake-up running
    localparam int ST_FRAMES_LSB = 8;  // completed frames, 8 bits
    localparam int ST_ABORTS_LSB = 16;  // aborted frames, 8 bits

    // channel register fields
    localparam int CHR_REG_LSB = 0;  // held register code
    localparam int CHR_OUT_LSB = 16;  // applied output code

    // operation modes
    typedef enum logic [1:0] {
        OP_WRITE_HOLD = 2'h0,  // write one, no update
        OP_WRITE_UPD = 2'h1,  // write one, update all
        OP_ALL_UPD = 2'h2,  // write all, update all
        OP_POWER_DOWN = 2'h3  // power down all
    } qdc_op_t;

    // output termination in power-down
    typedef enum logic [1:0] {
        TERM_HIZ = 2'h0,  // high impedance
        TERM_2K5 = 2'h1,  // 2.5 kohm to ground
        TERM_100K = 2'h2  // 100 kohm to ground
    } qdc_term_t;

    // frame layout, first bit sent in the msb
    typedef struct packed {
        logic channel_select_hi;  // channel / termination msb
        logic channel_select_lo;  // channel / termination lsb
        qdc_op_t op;  // operation_mode_hi, operation_mode_lo
        logic [11:0] code;  // straight binary code, msb first
    } qdc_frame_t;

    // serial pins
    typedef struct packed {
        logic sync_n;  // frame sync, active low
        logic sclk;  // serial clock
        logic din;  // serial data
    } qdc_link_t;

    // receiver states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,  // waiting for sync fall
        ST_SHIFT = 3'b010,  // shifting bits
        ST_HOLD = 3'b100  // frame done, ignoring edges
    } qdc_state_t;

endpackage

// *** src/qdc_sync2.sv ***
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser for pins from outside pclk
module qdc_sync2 #(
    parameter int WIDTH = 3  // number of bits
) (
    input wire logic clk,  // sampling clock
    input wire logic rst_n,  // async reset, active low
    input wire logic [WIDTH-1:0] d,  // asynchronous inputs
    output logic [WIDTH-1:0] q  // synchronised outputs
);

    logic [WIDTH-1:0] meta;  // first stage, read only by q

    // plain two-stage chain, resets low like idle sclk and din
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

`default_nettype wire

// *** src/qdc_serial_ctrl.sv ***
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RL1: after sync falls, shift din on sclk falls
// RL2: sixteenth fall completes frame and executes it
// RL3: edges after sixteenth fall are ignored
// RL4: master holds sync high between frames
// RL5: master never drops sync with sclk fall
// RL6: master sclk at most 40 MHz
// RL7: master idles sclk and din low
// RL8: frame order: channel, mode, twelve data bits
// RL9: data straight binary, msb first
// RL10: mode selects hold, update, all, power-down
// RL11: channel 0..3 is A..D; mode encodings
// RL12: early sync rise aborts, nothing changes
// RL13: reset clears registers, outputs zero until frame
// RL14: mode 11 powers down all channels
// RL15: channel bits choose power-down termination
// RL16: power-down keeps register contents
// RL17: leaving power-down restores held register values
// RL18: master stops sclk for lowest power-down
// RL19: each register holds 12-bit code 0..4095
// RL20: wake-up timed from sixteenth sclk fall
module qdc_serial_ctrl import qdc_pkg::*; #(
    parameter int WAKE_CYCLES = WAKEUP_CYCLES  // wake-up length, pclk
) (
    input wire logic pclk,  // system clock, 40 MHz
    input wire logic presetn,  // async reset, active low
    input wire logic psel,  // apb select
    input wire logic penable,  // apb access phase
    input wire logic pwrite,  // apb direction, high writes
    input wire logic [7:0] paddr,  // apb byte address
    input wire logic [31:0] pwdata,  // apb write data
    output logic [31:0] prdata,  // apb read data
    output logic pready,  // apb ready
    output logic pslverr,  // apb error, unmapped address
    input wire qdc_link_t link_in,  // serial pins, asynchronous
    output logic [NUM_CH-1:0][CODE_W-1:0] vout_code,  // applied codes
    output logic powered_down,  // all outputs shut down
    output qdc_term_t termination,  // termination while down
    output logic waking,  // wake-up time running
    output logic frame_done  // pulse per executed frame
);

    // does this frame write channel idx
    function automatic logic writes_channel(qdc_frame_t f, int idx);
        logic [1:0] sel;
        sel = {f.channel_select_hi, f.channel_select_lo};
        return (f.op == OP_ALL_UPD) ||
               ((f.op != OP_POWER_DOWN) && (sel == idx[1:0]));
    endfunction

    // termination picked by channel bits in power-down
    function automatic qdc_term_t term_of(qdc_frame_t f);
        unique case ({f.channel_select_hi, f.channel_select_lo})
            2'h1: return TERM_2K5;
            2'h2: return TERM_100K;
            default: return TERM_HIZ;  // 00 and 11 both float
        endcase
    endfunction

    logic [2:0] link_bits;  // synchronised pin bits
    qdc_link_t link_s;  // synchronised pins
    logic sclk_d;  // sclk one sample ago
    logic sync_d;  // sync_n one sample ago
    logic sclk_fall;  // falling sclk seen
    logic sync_fall;  // frame start
    logic sync_rise;  // frame end
    qdc_state_t state;  // receiver state
    qdc_state_t next_state;  // receiver state, next
    logic [3:0] bit_cnt;  // bits taken this frame
    logic [FRAME_BITS-2:0] shift_reg;  // first fifteen bits
    qdc_frame_t new_frame;  // frame as completed by last bit
    logic exec;  // sixteenth fall, act now
    logic abort;  // sync rose early
    logic update;  // this frame updates outputs
    logic [NUM_CH-1:0][CODE_W-1:0] dac_reg;  // held codes
    logic [WAKE_W-1:0] wake_cnt;  // wake-up countdown
    logic [7:0] frames;  // executed frames, wraps
    logic [7:0] aborts;  // aborted frames, wraps
    logic link_en;  // software enable for new frames
    logic seen_update;  // any output update since reset
    logic apb_setup;  // setup phase this cycle
    logic apb_write;  // write takes effect this cycle

    // pins cross into pclk before anything looks at them
    qdc_sync2 #(.WIDTH(3)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(link_in),
        .q(link_bits)
    );
    assign link_s = qdc_link_t'(link_bits);

    // previous samples for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            sclk_d <= link_s.sclk;
            sync_d <= link_s.sync_n;
        end
    end

    assign sclk_fall = sclk_d & ~link_s.sclk;
    assign sync_fall = sync_d & ~link_s.sync_n;
    assign sync_rise = ~sync_d & link_s.sync_n;

    // last bit joins the fifteen already held
    assign new_frame = qdc_frame_t'({shift_reg, link_s.din});  // RL8 RL9
    // sclk fall and sync rise may land in one sample; the fall wins
    assign exec = (state == ST_SHIFT) && sclk_fall &&
                  (bit_cnt == LAST_BIT);  // RL2
    assign abort = (state == ST_SHIFT) && sync_rise && !exec;  // RL12
    assign update = exec && ((new_frame.op == OP_WRITE_UPD) ||
                             (new_frame.op == OP_ALL_UPD));  // RL10 RL11

    // receiver next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                // an sclk fall in the start sample is not counted
                if (sync_fall && link_en) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (exec) begin
                    next_state = sync_rise ? ST_IDLE : ST_HOLD;
                end else if (sync_rise) begin
                    next_state = ST_IDLE;  // RL12
                end
            end
            ST_HOLD: begin
                // clocks and data ignored until sync returns high
                if (sync_rise) begin
                    next_state = ST_IDLE;  // RL3
                end
            end
            default: begin
                next_state = ST_IDLE;  // illegal code recovers
            end
        endcase
    end

    // receiver state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // bit counter and shift register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= 4'h0;
            shift_reg <= '0;
        end else if (state == ST_IDLE) begin
            bit_cnt <= 4'h0;
        end else if (state == ST_SHIFT && sclk_fall) begin
            bit_cnt <= bit_cnt + 4'h1;  // RL1
            shift_reg <= {shift_reg[FRAME_BITS-3:0], link_s.din};  // RL1
        end
    end

    // per-channel register and applied code
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic wr;  // this frame loads channel i
        assign wr = exec && writes_channel(new_frame, i);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                dac_reg[i] <= '0;  // RL13
                vout_code[i] <= '0;  // RL13
            end else begin
                if (wr) begin
                    dac_reg[i] <= new_frame.code;  // RL19
                end
                // restore uses held code unless this frame rewrote it
                if (update) begin
                    vout_code[i] <= wr ? new_frame.code : dac_reg[i];  // RL17
                end
            end
        end
    end

    // power-down and termination; registers untouched here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_down <= 1'b0;
            termination <= TERM_HIZ;
        end else if (exec && new_frame.op == OP_POWER_DOWN) begin
            powered_down <= 1'b1;  // RL14 RL16
            termination <= term_of(new_frame);  // RL15
        end else if (update) begin
            // a write-only frame leaves the outputs down
            powered_down <= 1'b0;  // RL17
        end
    end

    // wake-up window from the frame that ends power-down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt <= '0;
        end else if (update && powered_down) begin
            wake_cnt <= WAKE_W'(WAKE_CYCLES);  // RL20
        end else if (wake_cnt != '0) begin
            wake_cnt <= wake_cnt - WAKE_W'(1);
        end
    end
    assign waking = (wake_cnt != '0);

    // frame statistics and done pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames <= 8'h00;
            aborts <= 8'h00;
            frame_done <= 1'b0;
            seen_update <= 1'b0;
        end else begin
            frame_done <= exec;
            if (exec) begin
                frames <= frames + 8'h01;
            end
            if (abort) begin
                aborts <= aborts + 8'h01;
            end
            if (update) begin
                seen_update <= 1'b1;
            end
        end
    end

    // apb: zero wait states, error on unmapped words
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    assign pready = 1'b1;

    // address decode, word aligned only
    function automatic logic addr_ok(logic [7:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
               ((a[7:4] == ADDR_CH_BASE[7:4]) && (a[1:0] == 2'h0));
    endfunction

    assign pslverr = psel && penable && !addr_ok(paddr);

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_en <= CTRL_RESET[CTRL_EN_BIT];
        end else if (apb_write && paddr == ADDR_CTRL) begin
            // a disable lets a running frame finish
            link_en <= pwdata[CTRL_EN_BIT];
        end
    end

    // read data captured in setup, stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (apb_setup) begin
            prdata <= '0;
            if (paddr == ADDR_CTRL) begin
                prdata[CTRL_EN_BIT] <= link_en;
            end else if (paddr == ADDR_STATUS) begin
                prdata[ST_PD_BIT] <= powered_down;
                prdata[ST_TERM_LSB +: 2] <= termination;
                prdata[ST_BUSY_BIT] <= (state != ST_IDLE);
                prdata[ST_WAKE_BIT] <= waking;
                prdata[ST_FRAMES_LSB +: 8] <= frames;
                prdata[ST_ABORTS_LSB +: 8] <= aborts;
            end else if (addr_ok(paddr)) begin
                prdata[CHR_REG_LSB +: CODE_W] <= dac_reg[paddr[3:2]];
                prdata[CHR_OUT_LSB +: CODE_W] <= vout_code[paddr[3:2]];
            end
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_shift_in: assert property ( // RL1
        (state == ST_SHIFT && sclk_fall && !exec) |=>
        shift_reg[0] == $past(link_s.din) &&
        bit_cnt == $past(bit_cnt) + 4'h1)
        else $error("bit not shifted on sclk fall");

    a_exec_sixteenth: assert property ( // RL2
        exec |-> bit_cnt == LAST_BIT ##1 frame_done)
        else $error("frame executed on wrong edge");

    a_hold_ignores: assert property ( // RL3
        (state == ST_HOLD && !sync_rise) |=>
        state == ST_HOLD && $stable(shift_reg) && !exec)
        else $error("edges after last bit were used");

    a_abort_keeps: assert property ( // RL12
        abort |=> $stable(dac_reg) && $stable(vout_code) &&
        $stable(powered_down) && state == ST_IDLE)
        else $error("aborted frame changed state");

    a_zero_until_valid: assert property ( // RL13
        !seen_update |-> vout_code == '0)
        else $error("output moved before a valid update");

    a_pd_enter: assert property ( // RL14
        (exec && new_frame.op == OP_POWER_DOWN) |=>
        powered_down && termination == term_of($past(new_frame)))
        else $error("power-down or termination wrong");

    a_pd_keeps_regs: assert property ( // RL16
        (exec && new_frame.op == OP_POWER_DOWN) |=>
        $stable(dac_reg) && $stable(vout_code))
        else $error("power-down changed a register");

    a_all_update: assert property ( // RL10
        (exec && new_frame.op == OP_ALL_UPD) |=>
        vout_code == {NUM_CH{$past(new_frame.code)}} && !powered_down)
        else $error("write-all did not update outputs");

    a_hold_no_update: assert property ( // RL11
        (exec && new_frame.op == OP_WRITE_HOLD) |=> $stable(vout_code))
        else $error("write without update moved outputs");

    a_wake_start: assert property ( // RL20
        (update && powered_down) |=> wake_cnt == WAKE_W'(WAKE_CYCLES))
        else $error("wake-up not timed from last bit");

    c_power_down: cover property (exec && new_frame.op == OP_POWER_DOWN);
    c_abort: cover property (abort);
    c_wake: cover property (update && powered_down);
    c_full_scale: cover property (exec && new_frame.code == CODE_FULL);

endmodule

`default_nettype wire

// *** test/qdc_link_master.sv ***
`timescale 1ns/100ps
`default_nettype none

// serial master model; runs on its own time base, unrelated to pclk
module qdc_link_master import qdc_pkg::*; (
    output qdc_link_t link  // frame sync, serial clock, data
);
    localparam int HALF_NS = 100;  // half of the 200 ns link clock period
    localparam int SKEW_NS = 5;  // keeps pin edges clear of pclk edges

    // idle state: sync high, clock stopped low, data low
    initial begin
        link = '{sync_n: 1'b1, sclk: 1'b0, din: 1'b0};
    end

    // one frame, first bit sent is bit 15
    // fewer than 16 bits aborts; more than 16 adds stray edges and bits
    task automatic send(input logic [15:0] f, input int nbits);
        // callers return on a pclk edge; a pin moved there races the
        // synchroniser, so every edge of the frame is pushed off it
        #(SKEW_NS);
        link.sync_n = 1'b0;
        #(HALF_NS);
        for (int i = 0; i < nbits; i++) begin
            link.sclk = 1'b1;
            // stray bits toggle, so a shifted extra bit would show
            link.din = (i < FRAME_BITS) ? f[15-i] : ~link.din;
            #(HALF_NS);
            link.sclk = 1'b0;
            #(HALF_NS);
        end
        link.din = 1'b0;
        link.sync_n = 1'b1;
        #(2*HALF_NS);
    endtask
endmodule

`default_nettype wire

// *** test/quad_dac_serial_write_control_test.sv ***
`timescale 1ns/100ps
`default_nettype none

module quad_dac_serial_write_control_test import qdc_pkg::*;;
    localparam int WK = 10;  // short wake-up keeps the run brief
    logic pclk;  // 40 MHz system clock
    logic presetn;  // reset, active low
    logic psel;  // apb select
    logic penable;  // apb access phase
    logic pwrite;  // apb direction
    logic [7:0] paddr;  // apb address
    logic [31:0] pwdata;  // apb write data
    logic [31:0] prdata;  // apb read data
    logic pready;  // apb ready
    logic pslverr;  // apb error
    qdc_link_t link;  // serial pins from the master model
    logic [NUM_CH-1:0][CODE_W-1:0] vout_code;  // applied codes
    logic powered_down;  // outputs shut down
    qdc_term_t termination;  // termination while down
    logic waking;  // wake-up running
    logic frame_done;  // executed frame pulse
    int failures = 0;  // mismatches seen
    int tests_run = 0;  // comparisons made
    int done_cnt = 0;  // frame_done pulses seen
    int wake_len = 0;  // cycles with waking high
    int frm = 0;  // expected executed frames
    logic [31:0] rd;  // last read data
    logic er;  // last error flag

    qdc_serial_ctrl #(.WAKE_CYCLES(WK)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_in(link),
        .vout_code(vout_code), .powered_down(powered_down),
        .termination(termination), .waking(waking),
        .frame_done(frame_done)
    );
    qdc_link_master m_u (.link(link));

    always #12.5 pclk = ~pclk;

    // count pulses and wake cycles on the design's clock
    always @(posedge pclk) begin
        if (frame_done === 1'b1) done_cnt++;
        if (waking === 1'b1) wake_len++;
    end

    task tally_and_finish;
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task check(input string nm, input logic [47:0] got,
               input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; the wait for pready is bounded
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // send a frame, then let the synchroniser latency pass
    task frame(input logic [1:0] ch, input qdc_op_t op, input logic [11:0] c,
               input int nbits);
        m_u.send({ch, op, c}, nbits);
        repeat (2) @(posedge pclk);
    endtask

    // held register field of one channel
    task rdch(input int ch, input logic [11:0] exp);
        apb(1'b0, ADDR_CH_BASE + 8'(4 * ch), 32'h0000_0000);
        check("held code", rd[11:0], exp);
    endtask

    // frame and abort counters in status
    task rdstat;
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        check("frames", rd[15:8], 8'(frm));
        check("aborts", rd[23:16], 8'h01);
        check("pulses", done_cnt, frm);
    endtask

    initial begin
        int n;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        check("vout reset", vout_code, 48'h0);
        check("down reset", powered_down, 1'b0);
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        check("ctrl reset", rd, CTRL_RESET);
        for (int ch = 0; ch < NUM_CH; ch++) rdch(ch, 12'h000);
        // hold-only write to channel B
        frame(2'h1, OP_WRITE_HOLD, 12'hABC, 16);
        frm++;
        check("hold", vout_code, 48'h0);
        rdch(1, 12'hABC);
        // write A and update all
        frame(2'h0, OP_WRITE_UPD, 12'h123, 16);
        frm++;
        check("upd", vout_code, 48'h000_000_ABC_123);
        // write all at full scale
        frame(2'h3, OP_ALL_UPD, CODE_FULL, 16);
        frm++;
        check("all", vout_code, 48'hFFF_FFF_FFF_FFF);
        // early sync rise: nothing changes
        frame(2'h2, OP_WRITE_UPD, 12'h555, 10);
        check("abort", vout_code, 48'hFFF_FFF_FFF_FFF);
        rdch(2, 12'hFFF);
        // stray edges after the sixteenth bit are ignored
        frame(2'h2, OP_WRITE_UPD, 12'h000, 20);
        frm++;
        check("extra", vout_code, 48'hFFF_000_FFF_FFF);
        // every power-down termination
        for (int t = 0; t < 4; t++) begin
            frame(2'(t), OP_POWER_DOWN, 12'h000, 16);
            frm++;
            check("down", powered_down, 1'b1);
            check("term", termination, (t == 3) ? 2'h0 : 2'(t));
        end
        rdch(0, 12'hFFF);
        rdch(2, 12'h000);
        // leave power-down writing B; others keep held values
        wake_len = 0;
        frame(2'h1, OP_WRITE_UPD, 12'h456, 16);
        frm++;
        check("up", powered_down, 1'b0);
        check("wake", vout_code, 48'hFFF_000_456_FFF);
        n = 0;
        while (waking !== 1'b0 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 1000) begin
            // a wake-up that never ends is a hang, report at once
            failures++;
            tally_and_finish();
        end
        check("wake len", wake_len, WK);
        rdstat();
        // status is read-only; unmapped address errs
        apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
        rdstat();
        apb(1'b0, 8'h08, 32'h0000_0000);
        check("unmapped err", er, 1'b1);
        check("unmapped data", rd, 32'h0);
        // link disabled: frame not taken
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        frame(2'h0, OP_WRITE_UPD, 12'h777, 16);
        check("disabled", vout_code, 48'hFFF_000_456_FFF);
        apb(1'b1, ADDR_CTRL, CTRL_RESET);
        rdstat();
        tally_and_finish();
    end

    // hang guard
    initial begin
        #1000000;
        failures++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
